// ---- rtl/pin_formatter_io_interface.v ----
// Purpose: pin-level interface of a four-channel pattern timing formatter
// Assumes: every input synchronous to i_core_clk; formatter core supplies
//   per-channel drive value and drive enable requests
// Notes: open-drain legs are modelled as value plus output enable
//
// Functional notes
// (R1) Without burst valid, edges are disabled and drive/expect outputs hold static, except a drive value on channel 2 or 3 routed to the clean clock.
// (R2) Early T0 marker, sampled on the clock, starts a new T0 period.
// (R3) Early C0 marker, sampled on the clock, starts a new C0 period.
// (R4) Sampled 8-bit global delay is handed to every edge of every channel.
// (R5) Arm, start, stop outputs are differential tristate, both legs off when disabled.
// (R6) Each channel drives a true/complement drive-value pair to the driver.
// (R7) Each channel drives a true/complement drive-enable pair to the driver.
// (R8) Clean clock input can replace drive value on channels 2 and 3.
// (R9) High comparator reads 1 when the tested output is above high threshold.
// (R10) Low comparator reads 1 when the tested output is above low threshold.
// (R11) Each measurement mux selects any comparator result; select and enable are stored.
`timescale 1ns/1ps
`include "pin_formatter_consts.vh"
module pin_formatter_io_interface (
  input wire i_core_clk,
  input wire i_sys_rst,
  // sequencer side
  input wire i_burst_valid,
  input wire i_t0_period_start,
  input wire i_c0_period_start,
  input wire [7:0] i_global_delay,
  // formatter core side, one bit per channel
  input wire [3:0] i_fmt_drive_value,
  input wire [3:0] i_fmt_drive_on,
  input wire [3:0] i_fmt_expect_high,
  input wire [3:0] i_fmt_expect_low,
  // configuration
  input wire i_cfg_load,
  input wire [1:0] i_cfg_clk_route,
  input wire [2:0] i_cfg_arm_sel,
  input wire i_cfg_arm_en,
  input wire [2:0] i_cfg_start_sel,
  input wire i_cfg_start_en,
  input wire [2:0] i_cfg_stop_sel,
  input wire i_cfg_stop_en,
  // clean clock and comparator pairs
  input wire i_clean_clock_in_p,
  input wire i_clean_clock_in_n,
  input wire [3:0] i_cmp_high_p,
  input wire [3:0] i_cmp_high_n,
  input wire [3:0] i_cmp_low_p,
  input wire [3:0] i_cmp_low_n,
  // to edge generators and compare logic
  output reg o_edges_enabled,
  output reg [7:0] o_edge_delay,
  output reg [3:0] o_expect_high,
  output reg [3:0] o_expect_low,
  output reg [3:0] o_cmp_high,
  output reg [3:0] o_cmp_low,
  output reg o_t0_period_begin,
  output reg [15:0] o_t0_cycle,
  output reg o_c0_period_begin,
  output reg [15:0] o_c0_cycle,
  // drive value pairs
  output reg [3:0] o_drive_value_p,
  output reg [3:0] o_drive_value_p_oe,
  output reg [3:0] o_drive_value_n,
  output reg [3:0] o_drive_value_n_oe,
  // drive enable pairs
  output reg [3:0] o_drive_on_p,
  output reg [3:0] o_drive_on_p_oe,
  output reg [3:0] o_drive_on_n,
  output reg [3:0] o_drive_on_n_oe,
  // measurement outputs
  output wire o_meas_arm_out_p,
  output wire o_meas_arm_out_p_oe,
  output wire o_meas_arm_out_n,
  output wire o_meas_arm_out_n_oe,
  output wire o_meas_start_out_p,
  output wire o_meas_start_out_p_oe,
  output wire o_meas_start_out_n,
  output wire o_meas_start_out_n_oe,
  output wire o_meas_stop_out_p,
  output wire o_meas_stop_out_p_oe,
  output wire o_meas_stop_out_n,
  output wire o_meas_stop_out_n_oe
);

  localparam [1:0] ST_IDLE = `PF_ST_IDLE;
  localparam [1:0] ST_BURST = `PF_ST_BURST;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] route_q;
  reg [3:0] drive_value_q;
  reg [3:0] drive_on_q;
  reg [15:0] t0_cnt_q;
  reg [15:0] c0_cnt_q;
  wire [3:0] cmp_high_lvl;
  wire [3:0] cmp_low_lvl;
  wire clean_clock_lvl;
  wire [7:0] meas_src;
  wire [3:0] drive_value_mux;
  wire burst_run;

  ////////////////////////////////////////////////////////////////////////////
  // saturating period counter step, shared by both period trackers
  function [15:0] cnt_next;
    input start;
    input [15:0] cnt;
    begin
      if (start) begin
        cnt_next = `PF_PER_CNT_RST;
      end else if (cnt == `PF_PER_CNT_MAX) begin
        cnt_next = cnt;
      end else begin
        cnt_next = cnt + `PF_PER_CNT_ONE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator receivers; legs are differential, true leg high means above threshold
  genvar ch;
  generate
    for (ch = 0; ch < `PF_NUM_CH; ch = ch + 1) begin : g_cmp
      diff_rx u_cmp_high (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_p(i_cmp_high_p[ch]),
        .i_n(i_cmp_high_n[ch]),
        .o_level(cmp_high_lvl[ch])
      ); // (R9)
      diff_rx u_cmp_low (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_p(i_cmp_low_p[ch]),
        .i_n(i_cmp_low_n[ch]),
        .o_level(cmp_low_lvl[ch])
      ); // (R10)
      // even source = high comparator, odd source = low comparator of a channel
      assign meas_src[2*ch] = cmp_high_lvl[ch];
      assign meas_src[2*ch+1] = cmp_low_lvl[ch];
    end
  endgenerate

  // clean clock receiver; sampling it limits the routed clock to half the core rate
  diff_rx u_clean_clock (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_p(i_clean_clock_in_p),
    .i_n(i_clean_clock_in_n),
    .o_level(clean_clock_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // burst controller
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (i_burst_valid) begin
          state_d = ST_BURST;
        end
      end
      ST_BURST: begin
        if (!i_burst_valid) begin
          state_d = ST_IDLE; // (R1)
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // the qualifier is taken in the same cycle so no drive change leaks after it drops
  assign burst_run = i_burst_valid;

  ////////////////////////////////////////////////////////////////////////////
  // edge qualifier and global delay toward every edge generator
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_edges_enabled <= 1'b0;
      o_edge_delay <= `PF_DELAY_RST;
    end else begin
      o_edges_enabled <= (state_d == ST_BURST); // (R1)
      o_edge_delay <= i_global_delay; // (R4)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive and expect state: frozen at its last value outside a burst
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      drive_value_q <= `PF_NIB_RST;
      drive_on_q <= `PF_NIB_RST;
      o_expect_high <= `PF_NIB_RST;
      o_expect_low <= `PF_NIB_RST;
    end else if (burst_run) begin
      drive_value_q <= i_fmt_drive_value;
      drive_on_q <= i_fmt_drive_on;
      o_expect_high <= i_fmt_expect_high;
      o_expect_low <= i_fmt_expect_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator results toward compare logic
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_cmp_high <= `PF_NIB_RST;
      o_cmp_low <= `PF_NIB_RST;
    end else begin
      o_cmp_high <= cmp_high_lvl; // (R9)
      o_cmp_low <= cmp_low_lvl; // (R10)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period trackers; cycle 0 is the marked cycle itself
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      t0_cnt_q <= `PF_PER_CNT_RST;
      c0_cnt_q <= `PF_PER_CNT_RST;
      o_t0_period_begin <= 1'b0;
      o_c0_period_begin <= 1'b0;
      o_t0_cycle <= `PF_PER_CNT_RST;
      o_c0_cycle <= `PF_PER_CNT_RST;
    end else begin
      t0_cnt_q <= cnt_next(i_t0_period_start, t0_cnt_q); // (R2)
      c0_cnt_q <= cnt_next(i_c0_period_start, c0_cnt_q); // (R3)
      o_t0_period_begin <= i_t0_period_start; // (R2)
      o_c0_period_begin <= i_c0_period_start; // (R3)
      o_t0_cycle <= cnt_next(i_t0_period_start, t0_cnt_q);
      o_c0_cycle <= cnt_next(i_c0_period_start, c0_cnt_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock routing selection, loaded with the rest of the configuration
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      route_q <= `PF_ROUTE_RST;
    end else if (i_cfg_load) begin
      route_q <= i_cfg_clk_route;
    end
  end

  // channels 0 and 1 always carry formatted data; 2 and 3 may carry the clean clock
  assign drive_value_mux[1:0] = drive_value_q[1:0];
  assign drive_value_mux[2] = route_q[0] ? clean_clock_lvl : drive_value_q[2]; // (R8)
  assign drive_value_mux[3] = route_q[1] ? clean_clock_lvl : drive_value_q[3]; // (R8)

  ////////////////////////////////////////////////////////////////////////////
  // differential open-drain pairs: exactly one leg is pulled low at any time
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_drive_value_p <= `PF_NIB_RST;
      o_drive_value_n <= `PF_NIB_RST;
      o_drive_value_p_oe <= ~`PF_NIB_RST;
      o_drive_value_n_oe <= `PF_NIB_RST;
      o_drive_on_p <= `PF_NIB_RST;
      o_drive_on_n <= `PF_NIB_RST;
      o_drive_on_p_oe <= ~`PF_NIB_RST;
      o_drive_on_n_oe <= `PF_NIB_RST;
    end else begin
      o_drive_value_p <= `PF_NIB_RST;
      o_drive_value_n <= `PF_NIB_RST;
      o_drive_value_p_oe <= ~drive_value_mux; // (R6)
      o_drive_value_n_oe <= drive_value_mux; // (R6)
      o_drive_on_p <= `PF_NIB_RST;
      o_drive_on_n <= `PF_NIB_RST;
      o_drive_on_p_oe <= ~drive_on_q; // (R7)
      o_drive_on_n_oe <= drive_on_q; // (R7)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement multiplexers: arm, start, stop
  meas_mux u_arm (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(i_cfg_load),
    .i_sel(i_cfg_arm_sel),
    .i_en(i_cfg_arm_en),
    .i_src(meas_src),
    .o_p(o_meas_arm_out_p),
    .o_p_oe(o_meas_arm_out_p_oe),
    .o_n(o_meas_arm_out_n),
    .o_n_oe(o_meas_arm_out_n_oe)
  ); // (R5)

  meas_mux u_start (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(i_cfg_load),
    .i_sel(i_cfg_start_sel),
    .i_en(i_cfg_start_en),
    .i_src(meas_src),
    .o_p(o_meas_start_out_p),
    .o_p_oe(o_meas_start_out_p_oe),
    .o_n(o_meas_start_out_n),
    .o_n_oe(o_meas_start_out_n_oe)
  ); // (R5)

  meas_mux u_stop (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(i_cfg_load),
    .i_sel(i_cfg_stop_sel),
    .i_en(i_cfg_stop_en),
    .i_src(meas_src),
    .o_p(o_meas_stop_out_p),
    .o_p_oe(o_meas_stop_out_p_oe),
    .o_n(o_meas_stop_out_n),
    .o_n_oe(o_meas_stop_out_n_oe)
  ); // (R5)

endmodule // pin_formatter_io_interface

// ---- include/pin_formatter_consts.vh ----
// Purpose: shared constants of the pin formatter pin interface
// Assumes: included by its bare name from the top module and meas_mux
// Notes: definitions only
`ifndef PIN_FORMATTER_CONSTS_VH
`define PIN_FORMATTER_CONSTS_VH

// channel and source counts
`define PF_NUM_CH 4
`define PF_NUM_SRC 8
`define PF_SEL_W 3

// reset values of configuration state
`define PF_SEL_RST 3'h0
`define PF_EN_RST 1'b0
`define PF_ROUTE_RST 2'h0
`define PF_DELAY_RST 8'h00
`define PF_NIB_RST 4'h0

// period cycle counters
`define PF_PER_CNT_W 16
`define PF_PER_CNT_RST 16'h0000
`define PF_PER_CNT_ONE 16'h0001
`define PF_PER_CNT_MAX 16'hffff

// burst controller states, one-hot
`define PF_ST_IDLE 2'h1
`define PF_ST_BURST 2'h2

`endif

// ---- rtl/diff_rx.v ----
// Purpose: differential receiver for one input pair
// Assumes: both legs synchronous to the core clock
// Notes: a pair with equal legs is not a valid level and holds the last one
`timescale 1ns/1ps
module diff_rx (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_p,
  input wire i_n,
  output reg o_level
);

  ////////////////////////////////////////////////////////////////////////////
  // true leg wins when the legs differ; equal legs mean a glitch or idle pair
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_level <= 1'b0;
    end else if (i_p ^ i_n) begin
      o_level <= i_p;
    end
  end

endmodule // diff_rx

// ---- rtl/meas_mux.v ----
// Purpose: one 8-to-1 measurement multiplexer with differential tristate output
// Assumes: source vector holds high/low comparator results, two per channel
// Notes: selection and enable are loaded together on i_load
`timescale 1ns/1ps
`include "pin_formatter_consts.vh"
module meas_mux (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_load,
  input wire [2:0] i_sel,
  input wire i_en,
  input wire [7:0] i_src,
  output reg o_p,
  output reg o_p_oe,
  output reg o_n,
  output reg o_n_oe
);

  reg [2:0] sel_q;
  reg en_q;
  wire value;

  ////////////////////////////////////////////////////////////////////////////
  // configuration state, kept until the next load
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sel_q <= `PF_SEL_RST;
      en_q <= `PF_EN_RST;
    end else if (i_load) begin
      sel_q <= i_sel; // (R11)
      en_q <= i_en; // (R11)
    end
  end

  assign value = i_src[sel_q]; // (R11)

  ////////////////////////////////////////////////////////////////////////////
  // open-drain legs: the leg pulled low carries the level; disabled means both off
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_p <= 1'b0;
      o_n <= 1'b0;
      o_p_oe <= 1'b0;
      o_n_oe <= 1'b0;
    end else begin
      o_p <= 1'b0;
      o_n <= 1'b0;
      o_p_oe <= en_q & ~value; // (R5)
      o_n_oe <= en_q & value; // (R5)
    end
  end

endmodule // meas_mux

// ---- testbench/pin_formatter_io_interface_properties.sv ----
// Purpose: concurrent checks on the pin formatter pin interface
// Assumes: every input synchronous to i_core_clk
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module pin_formatter_io_interface_properties (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_burst_valid,
  input wire i_t0_period_start,
  input wire i_c0_period_start,
  input wire [7:0] i_global_delay,
  input wire i_cfg_load,
  input wire i_cfg_arm_en,
  input wire i_cfg_start_en,
  input wire [3:0] i_cmp_high_p,
  input wire [3:0] i_cmp_high_n,
  input wire [3:0] i_cmp_low_p,
  input wire [3:0] i_cmp_low_n,
  input wire o_edges_enabled,
  input wire [7:0] o_edge_delay,
  input wire [3:0] o_expect_high,
  input wire [3:0] o_expect_low,
  input wire [3:0] o_cmp_high,
  input wire [3:0] o_cmp_low,
  input wire o_t0_period_begin,
  input wire [15:0] o_t0_cycle,
  input wire [15:0] o_c0_cycle,
  input wire [3:0] o_drive_value_p_oe,
  input wire [3:0] o_drive_value_n_oe,
  input wire [3:0] o_drive_on_p_oe,
  input wire [3:0] o_drive_on_n_oe,
  input wire o_meas_arm_out_p_oe,
  input wire o_meas_arm_out_n_oe,
  input wire o_meas_start_out_p_oe,
  input wire o_meas_start_out_n_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // two idle samples: the two-stage drive path must then stand still
  sequence idle_two;
    !i_burst_valid ##1 !i_burst_valid;
  endsequence
  // a lone c0 marker, so the count is not restarted underneath us
  sequence c0_lone;
    i_c0_period_start ##1 !i_c0_period_start;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  edges_off_a: assert property (!i_burst_valid |=> !o_edges_enabled)
    else $error("edges enabled outside a burst");
  edges_on_a: assert property (i_burst_valid |=> o_edges_enabled)
    else $error("edges disabled inside a burst");
  expect_hold_a: assert property (!i_burst_valid |=> $stable({o_expect_high, o_expect_low}))
    else $error("expect outputs moved outside a burst");
  drive_hold_a: assert property (idle_two |=> $stable({o_drive_value_p_oe, o_drive_on_p_oe}))
    else $error("drive legs moved outside a burst");
  t0_begin_a: assert property (i_t0_period_start |=> o_t0_period_begin && o_t0_cycle == 16'h0000)
    else $error("t0 period did not begin");
  c0_count_a: assert property (c0_lone |=> o_c0_cycle == 16'h0001)
    else $error("c0 cycle index wrong");
  delay_pass_a: assert property (1'b1 |=> o_edge_delay == $past(i_global_delay))
    else $error("edge delay not the sampled value");
  value_pair_a: assert property (o_drive_value_p_oe == ~o_drive_value_n_oe)
    else $error("drive value legs not complementary");
  on_pair_a: assert property (o_drive_on_p_oe == ~o_drive_on_n_oe)
    else $error("drive enable legs not complementary");
  arm_off_a: assert property (i_cfg_load && !i_cfg_arm_en |=> ##1 !(o_meas_arm_out_p_oe || o_meas_arm_out_n_oe))
    else $error("disabled arm output still driven");
  start_on_a: assert property (i_cfg_load && i_cfg_start_en |=> ##1 o_meas_start_out_p_oe != o_meas_start_out_n_oe)
    else $error("enabled start output not one leg active");
  cmp_high_a: assert property (i_cmp_high_p == ~i_cmp_high_n |-> ##2 o_cmp_high == $past(i_cmp_high_p, 2))
    else $error("high comparator decode wrong");
  cmp_low_a: assert property (i_cmp_low_p == ~i_cmp_low_n |-> ##2 o_cmp_low == $past(i_cmp_low_p, 2))
    else $error("low comparator decode wrong");
endmodule // pin_formatter_io_interface_properties

bind pin_formatter_io_interface pin_formatter_io_interface_properties u_props (.*);

// ---- testbench/pin_electronics_model.sv ----
// Purpose: behavioural pin electronics: comparators, clean clock, driver inputs
// Assumes: bench changes the level codes at the falling clock edge
// Notes: level code per channel: 0 below low threshold, 1 between, 2 above high
`timescale 1ns/1ps
module pin_electronics_model (
  input wire i_core_clk,
  input wire i_clk_run,
  input wire [7:0] i_dut_lvl,
  input wire [3:0] i_value_p_oe,
  input wire [3:0] i_on_p_oe,
  output wire o_clk_p,
  output wire o_clk_n,
  output wire [3:0] o_cmp_high_p,
  output wire [3:0] o_cmp_high_n,
  output wire [3:0] o_cmp_low_p,
  output wire [3:0] o_cmp_low_n,
  output wire [3:0] o_seen_value,
  output wire [3:0] o_seen_on
);
  logic clk_q = 1'b0;
  logic div_q = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // clean clock at a quarter of core rate, since the block samples it; stands outside runs
  always @(negedge i_core_clk) begin
    if (i_clk_run) begin
      div_q <= ~div_q;
      if (div_q) begin
        clk_q <= ~clk_q;
      end
    end
  end
  assign o_clk_p = clk_q;
  assign o_clk_n = ~clk_q;
  // comparator pairs from the level code of each channel
  for (genvar c = 0; c < 4; c = c + 1) begin : g_ch
    assign o_cmp_high_p[c] = (i_dut_lvl[2*c+:2] == 2'h2);
    assign o_cmp_low_p[c] = (i_dut_lvl[2*c+:2] != 2'h0);
  end
  assign o_cmp_high_n = ~o_cmp_high_p;
  assign o_cmp_low_n = ~o_cmp_low_p;
  // pulled-up true leg reads high unless the block pulls it low
  assign o_seen_value = ~i_value_p_oe;
  assign o_seen_on = ~i_on_p_oe;
endmodule // pin_electronics_model

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the pin formatter pin interface
// Assumes: inputs change at the falling clock edge only
// Notes: driver and comparator side is a behavioural model
`timescale 1ns/1ps
module testbench;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_burst_valid = 1'b0, i_t0_period_start = 1'b0, i_c0_period_start = 1'b0;
  logic i_cfg_load = 1'b0, i_cfg_arm_en = 1'b0, i_cfg_start_en = 1'b0, i_cfg_stop_en = 1'b0;
  logic [7:0] i_global_delay = 8'h00;
  logic [3:0] i_fmt_drive_value = 4'h0, i_fmt_drive_on = 4'h0;
  logic [3:0] i_fmt_expect_high = 4'h0, i_fmt_expect_low = 4'h0;
  logic [1:0] i_cfg_clk_route = 2'h0;
  logic [2:0] i_cfg_arm_sel = 3'h0, i_cfg_start_sel = 3'h0, i_cfg_stop_sel = 3'h0;
  logic clk_run = 1'b0;
  logic [7:0] dut_lvl = 8'h00;
  logic [1:0] clk_hist = 2'h0;
  wire i_clean_clock_in_p, i_clean_clock_in_n;
  wire [3:0] i_cmp_high_p, i_cmp_high_n, i_cmp_low_p, i_cmp_low_n, seen_value, seen_on;
  wire o_edges_enabled, o_t0_period_begin, o_c0_period_begin;
  wire [7:0] o_edge_delay;
  wire [15:0] o_t0_cycle, o_c0_cycle;
  wire [3:0] o_expect_high, o_expect_low, o_cmp_high, o_cmp_low;
  wire [3:0] o_drive_value_p, o_drive_value_p_oe, o_drive_value_n, o_drive_value_n_oe;
  wire [3:0] o_drive_on_p, o_drive_on_p_oe, o_drive_on_n, o_drive_on_n_oe;
  wire o_meas_arm_out_p, o_meas_arm_out_p_oe, o_meas_arm_out_n, o_meas_arm_out_n_oe;
  wire o_meas_start_out_p, o_meas_start_out_p_oe, o_meas_start_out_n, o_meas_start_out_n_oe;
  wire o_meas_stop_out_p, o_meas_stop_out_p_oe, o_meas_stop_out_n, o_meas_stop_out_n_oe;
  int err_count = 0, n_tests = 0, cycles = 0;
  //////////////////////////////////////////////////////////////////////////////
  pin_formatter_io_interface u_pin_formatter_io_interface (.*);
  pin_electronics_model u_pin_electronics_model (.i_core_clk(i_core_clk), .i_clk_run(clk_run),
    .i_dut_lvl(dut_lvl), .i_value_p_oe(o_drive_value_p_oe), .i_on_p_oe(o_drive_on_p_oe),
    .o_clk_p(i_clean_clock_in_p), .o_clk_n(i_clean_clock_in_n), .o_cmp_high_p(i_cmp_high_p),
    .o_cmp_high_n(i_cmp_high_n), .o_cmp_low_p(i_cmp_low_p), .o_cmp_low_n(i_cmp_low_n),
    .o_seen_value(seen_value), .o_seen_on(seen_on));
  //////////////////////////////////////////////////////////////////////////////
  // clock, cycle ceiling against hangs, and clean clock history for the route check
  always #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    clk_hist <= {clk_hist[0], i_clean_clock_in_p};
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      stop_test;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // configuration load, one strobe cycle
  task cfg(input logic [1:0] r, input logic [3:0] a, input logic [3:0] s, input logic [3:0] p);
    {i_cfg_load, i_cfg_clk_route, i_cfg_arm_sel, i_cfg_arm_en} = {1'b1, r, a};
    {i_cfg_start_sel, i_cfg_start_en, i_cfg_stop_sel, i_cfg_stop_en} = {s, p};
    cyc(1);
    i_cfg_load = 1'b0;
    cyc(2);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    cyc(1);
    chk({o_drive_value_p_oe, o_drive_on_p_oe}, 8'hff, "true legs after reset");
    chk({o_drive_value_n_oe, o_drive_on_n_oe}, 8'h00, "false legs after reset");
    chk({o_meas_arm_out_p_oe, o_meas_arm_out_n_oe, o_meas_stop_out_p_oe}, 3'h0, "meas off");
    $display("reset test done");
  endtask
  task t_burst;
    {i_burst_valid, i_fmt_drive_value, i_fmt_drive_on} = {1'b1, 4'ha, 4'h6};
    {i_fmt_expect_high, i_fmt_expect_low} = 8'h3c;
    cyc(3);
    chk(o_edges_enabled, 1'b1, "edges in burst");
    chk({seen_value, seen_on}, 8'ha6, "driver pins in burst");
    chk({o_drive_value_n_oe, o_drive_on_n_oe}, 8'ha6, "false legs in burst");
    chk({o_drive_value_p, o_drive_value_n, o_drive_on_p, o_drive_on_n}, 16'h0000, "pulls");
    chk({o_expect_high, o_expect_low}, 8'h3c, "expect in burst");
    {i_burst_valid, i_fmt_drive_value, i_fmt_drive_on} = {1'b0, 4'h5, 4'h9};
    {i_fmt_expect_high, i_fmt_expect_low} = 8'hc3;
    cyc(3);
    chk(o_edges_enabled, 1'b0, "edges outside burst");
    chk({seen_value, seen_on}, 8'ha6, "driver pins held");
    chk({o_expect_high, o_expect_low}, 8'h3c, "expect held");
    $display("burst test done");
  endtask
  task t_period;
    i_t0_period_start = 1'b1;
    cyc(1);
    i_t0_period_start = 1'b0;
    chk({o_t0_period_begin, o_t0_cycle}, 17'h1_0000, "t0 begin");
    cyc(4);
    chk({o_t0_period_begin, o_t0_cycle}, 17'h0_0004, "t0 index");
    i_c0_period_start = 1'b1;
    cyc(2);
    i_c0_period_start = 1'b0;
    chk({o_c0_period_begin, o_c0_cycle}, 17'h1_0000, "c0 restart");
    cyc(1);
    chk({o_c0_period_begin, o_c0_cycle}, 17'h0_0001, "c0 index");
    $display("period test done");
  endtask
  task t_delay;
    logic [7:0] dv [3] = '{8'hff, 8'h5a, 8'h01};
    for (int k = 0; k < 3; k++) begin
      i_global_delay = dv[k];
      cyc(1);
      chk(o_edge_delay, dv[k], "edge delay");
    end
    $display("delay test done");
  endtask
  task t_cmp;
    dut_lvl = 8'h89;
    cyc(2);
    chk({o_cmp_high, o_cmp_low}, 8'hab, "comparators a");
    dut_lvl = 8'h24;
    cyc(2);
    chk({o_cmp_high, o_cmp_low}, 8'h46, "comparators b");
    $display("comparator test done");
  endtask
  task t_meas;
    cfg(2'h0, {3'h3, 1'b1}, {3'h0, 1'b1}, {3'h5, 1'b0});
    chk({o_meas_arm_out_p_oe, o_meas_arm_out_n_oe}, 2'h1, "arm low ch1");
    chk({o_meas_start_out_p_oe, o_meas_start_out_n_oe}, 2'h2, "start high ch0");
    chk({o_meas_stop_out_p_oe, o_meas_stop_out_n_oe}, 2'h0, "stop off");
    chk({o_meas_arm_out_p, o_meas_arm_out_n, o_meas_start_out_p, o_meas_start_out_n,
      o_meas_stop_out_p, o_meas_stop_out_n}, 6'h00, "pull values");
    cfg(2'h0, {3'h3, 1'b0}, {3'h4, 1'b1}, {3'h5, 1'b1});
    chk({o_meas_arm_out_p_oe, o_meas_arm_out_n_oe}, 2'h0, "arm off");
    chk({o_meas_start_out_p_oe, o_meas_stop_out_p_oe}, 2'h0, "start stop sources");
    $display("measurement test done");
  endtask
  task t_route;
    i_burst_valid = 1'b1;
    clk_run = 1'b1;
    cfg(2'h3, 4'h0, 4'h0, 4'h0);
    for (int k = 0; k < 8; k++) begin
      chk(seen_value[3:2], {2{clk_hist[1]}}, "clock on ch2 ch3");
      cyc(1);
    end
    // single-channel routes: the other channel keeps its formatted data
    cfg(2'h1, 4'h0, 4'h0, 4'h0);
    for (int k = 0; k < 6; k++) begin
      chk(seen_value[3:2], {i_fmt_drive_value[3], clk_hist[1]}, "clock on ch2 only");
      cyc(1);
    end
    cfg(2'h2, 4'h0, 4'h0, 4'h0);
    for (int k = 0; k < 6; k++) begin
      chk(seen_value[3:2], {clk_hist[1], i_fmt_drive_value[2]}, "clock on ch3 only");
      cyc(1);
    end
    clk_run = 1'b0;
    cfg(2'h0, 4'h0, 4'h0, 4'h0);
    chk(seen_value, i_fmt_drive_value, "data back on pins");
    $display("route test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence: reset for five cycles, then each scenario in turn
  initial begin
    cyc(5);
    i_sys_rst = 1'b0;
    t_reset;
    t_burst;
    t_period;
    t_delay;
    t_cmp;
    t_meas;
    t_route;
    stop_test;
  end
endmodule // testbench
